// ### design/ebla_top.sv
// external bus lane alignment: steers and splits internal accesses onto byte lanes
`timescale 1ns/1ps
module ebla_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic endian_select_pin,
   input wire ebla_pkg::ebla_width_type dev_width,
   input wire logic req_valid,
   input wire logic req_write,
   input wire ebla_pkg::ebla_size_type req_size,
   input wire logic [1:0] req_offset,
   input wire logic [31:0] req_wdata,
   output logic req_ready,
   output logic rsp_done,
   output logic [31:0] rsp_rdata,
   output logic ext_valid,
   output logic ext_write,
   output logic ext_last,
   output logic [1:0] ext_offset,
   output logic [31:0] ext_wdata,
   input wire logic [31:0] ext_rdata,
   output logic lane0_write_strobe,
   output logic lane1_write_strobe,
   output logic lane2_write_strobe,
   output logic lane3_write_strobe,
   output logic lane0_byte_mask,
   output logic lane1_byte_mask,
   output logic lane2_byte_mask,
   output logic lane3_byte_mask
);
   import ebla_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   typedef enum logic [1:0] {EBLA_START, EBLA_IDLE, EBLA_XFER} ebla_state_type;
   ebla_state_type state_q;        // sequencer state
   logic le_q;                     // little endian when set
   logic ready_q;                  // request may be taken
   logic done_q;                   // access finished pulse
   logic accept;                   // request taken this cycle
   logic write_q;                  // latched direction
   ebla_width_type width_q;        // latched device width
   ebla_size_type size_q;          // latched access size
   logic [1:0] off_q;              // latched offset
   logic [31:0] wdata_q;           // latched write data
   logic [1:0] cyc_q;              // split cycle index
   logic ev_q, ew_q, el_q;         // external cycle flags
   logic [1:0] eoff_q;             // external cycle offset
   logic [31:0] edata_q, edata_d;  // external write data
   logic [3:0] mask_q;             // lanes in use
   logic [3:0] strobe_q;           // lanes written this cycle
   logic [1:0] sel_q [4];          // access byte per lane, kept for read capture
   logic [31:0] rdata_q;           // assembled read data

   ebla_map_if mif ();

   // lane map on the latched request
   assign mif.little_endian = le_q;
   assign mif.width = width_q;
   assign mif.size = size_q;
   assign mif.base = off_q;
   assign mif.cyc = cyc_q;

   ebla_lane_map u_map (
      .m (mif.map)
   );

   assign accept = req_valid && ready_q;

   // ****************************************************************
   // endian capture and sequencer
   // ****************************************************************
   // pin taken on the first edge after reset release, then frozen
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         le_q <= 1'b0;
      end else if (state_q == EBLA_START) begin
         le_q <= endian_select_pin;
      end
   end

   // one split cycle per clock until the last
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= EBLA_START;
         cyc_q <= 2'd0;
      end else begin
         case (state_q)
            EBLA_START: begin
               state_q <= EBLA_IDLE;
            end
            EBLA_IDLE: begin
               cyc_q <= 2'd0;
               if (accept) begin
                  state_q <= EBLA_XFER;
               end
            end
            EBLA_XFER: begin
               cyc_q <= cyc_q + 2'd1;
               if (mif.last) begin
                  state_q <= EBLA_IDLE;
               end
            end
            default: begin
               state_q <= EBLA_IDLE;
            end
         endcase
      end
   end

   // request latch
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         write_q <= 1'b0;
         width_q <= EBLA_DEV8;
         size_q <= EBLA_BYTE;
         off_q <= EBLA_OFF_RST;
         wdata_q <= EBLA_DATA_RST;
      end else if (accept) begin
         write_q <= req_write;
         width_q <= dev_width;
         size_q <= req_size;
         off_q <= req_offset;
         wdata_q <= req_wdata;
      end
   end

   // ready while idle and nothing is pending; done once all cycles are out
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ready_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= ev_q && el_q;
         if (accept) begin
            ready_q <= 1'b0;
         end else if ((state_q == EBLA_START) || (ev_q && el_q)) begin
            ready_q <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // lane steering
   // ****************************************************************
   // each lane carries its selected access byte; unused lanes drive zero
   always_comb begin
      edata_d = EBLA_DATA_RST;
      for (int k = 0; k < EBLA_LANES; k++) begin
         if (mif.lane_en[k]) begin
            edata_d[8*k +: 8] = wdata_q[8*mif.lane_sel[k] +: 8];
         end
      end
   end

   // external cycle registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ev_q <= 1'b0;
         ew_q <= 1'b0;
         el_q <= 1'b0;
         eoff_q <= EBLA_OFF_RST;
         edata_q <= EBLA_DATA_RST;
         mask_q <= EBLA_NO_LANES;
         strobe_q <= EBLA_NO_LANES;
         for (int k = 0; k < EBLA_LANES; k++) begin
            sel_q[k] <= 2'd0;
         end
      end else if (state_q == EBLA_XFER) begin
         ev_q <= 1'b1;
         ew_q <= write_q;
         el_q <= mif.last;
         eoff_q <= mif.cyc_off;
         edata_q <= edata_d;
         mask_q <= mif.lane_en;
         // write strobes only on a write, only on lanes that carry data
         strobe_q <= write_q ? mif.lane_en : EBLA_NO_LANES;
         sel_q <= mif.lane_sel;
      end else begin
         // no cycle: every strobe and mask negated
         ev_q <= 1'b0;
         ew_q <= 1'b0;
         el_q <= 1'b0;
         mask_q <= EBLA_NO_LANES;
         strobe_q <= EBLA_NO_LANES;
      end
   end

   // read bytes gathered from the lanes in use
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= EBLA_DATA_RST;
      end else if (accept) begin
         rdata_q <= EBLA_DATA_RST;
      end else if (ev_q && !ew_q) begin
         for (int k = 0; k < EBLA_LANES; k++) begin
            if (mask_q[k]) begin
               rdata_q[8*sel_q[k] +: 8] <= ext_rdata[8*k +: 8];
            end
         end
      end
   end

   // outputs straight from flip-flops
   assign req_ready = ready_q;
   assign rsp_done = done_q;
   assign rsp_rdata = rdata_q;
   assign ext_valid = ev_q;
   assign ext_write = ew_q;
   assign ext_last = el_q;
   assign ext_offset = eoff_q;
   assign ext_wdata = edata_q;
   assign lane0_byte_mask = mask_q[0];
   assign lane1_byte_mask = mask_q[1];
   assign lane2_byte_mask = mask_q[2];
   assign lane3_byte_mask = mask_q[3];
   assign lane0_write_strobe = strobe_q[0];
   assign lane1_write_strobe = strobe_q[1];
   assign lane2_write_strobe = strobe_q[2];
   assign lane3_write_strobe = strobe_q[3];

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic take32, take16, take8;    // request taken per device width
   assign take32 = accept && (dev_width == EBLA_DEV32);
   assign take16 = accept && (dev_width == EBLA_DEV16);
   assign take8 = accept && (dev_width == EBLA_DEV8);

   narrow_lane_a: assert property (ev_q && width_q == EBLA_DEV8 |-> mask_q == 4'h1)
      else $error("8-bit cycle not on lowest lane only");
   be8_long_a: assert property (take8 && !le_q && req_size == EBLA_LONG |->
      ##2 edata_q[7:0] == wdata_q[31:24] && eoff_q == 2'd0
      ##3 edata_q[7:0] == wdata_q[7:0] && eoff_q == 2'd3 && el_q)
      else $error("8-bit big endian longword order wrong");
   le32_byte_a: assert property (take32 && le_q && req_size == EBLA_BYTE |->
      ##2 mask_q == (4'h1 << off_q))
      else $error("32-bit little endian byte on wrong lane");
   le32_word_a: assert property (take32 && le_q && req_size == EBLA_WORD && req_offset[1] |->
      ##2 mask_q == 4'hC && edata_q[31:24] == wdata_q[15:8])
      else $error("32-bit little endian upper word misplaced");
   full_long_a: assert property (take32 && req_size == EBLA_LONG |->
      ##2 mask_q == EBLA_ALL_LANES && el_q && edata_q == wdata_q)
      else $error("32-bit longword not one full cycle");
   half_byte_a: assert property (ev_q && width_q == EBLA_DEV16 && size_q == EBLA_BYTE |->
      mask_q == ((le_q ^ off_q[0]) ? 4'h1 : 4'h2))
      else $error("16-bit byte on wrong lane");
   le16_long_a: assert property (take16 && le_q && req_size == EBLA_LONG |->
      ##2 mask_q == 4'h3 && edata_q[15:0] == wdata_q[15:0] && !el_q
      ##1 eoff_q == 2'd2 && edata_q[15:0] == wdata_q[31:16] && el_q)
      else $error("16-bit little endian longword order wrong");
   le8_long_a: assert property (take8 && le_q && req_size == EBLA_LONG |->
      ##2 edata_q[7:0] == wdata_q[7:0] ##3 edata_q[7:0] == wdata_q[31:24] && el_q)
      else $error("8-bit little endian longword order wrong");
   be16_long_a: assert property (take16 && !le_q && req_size == EBLA_LONG |->
      ##2 edata_q[15:0] == wdata_q[31:16] ##1 edata_q[15:0] == wdata_q[15:0] && el_q)
      else $error("16-bit big endian longword order wrong");
   endian_hold_a: assert property (state_q != EBLA_START |=> $stable(le_q))
      else $error("endian mode changed after reset");
   idle_lanes_a: assert property (!ev_q |-> mask_q == EBLA_NO_LANES && strobe_q == EBLA_NO_LANES)
      else $error("strobe active outside a cycle");
   write_strobe_a: assert property (ev_q |-> strobe_q == (ew_q ? mask_q : EBLA_NO_LANES))
      else $error("write strobes differ from lanes in use");
   split_order_a: assert property (ev_q && !el_q |=> ev_q && eoff_q > $past(eoff_q))
      else $error("split cycles not back to back ascending");

   long8_c: cover property (take8 && req_size == EBLA_LONG ##5 done_q);
   long16_c: cover property (take16 && req_size == EBLA_LONG ##3 done_q);
   read32_c: cover property (take32 && !req_write ##2 done_q);
   word32_c: cover property (take32 && req_size == EBLA_WORD);
endmodule

// ### design/ebla_pkg.sv
// shared types and constants of the external bus lane alignment block
package ebla_pkg;
   // ****************************************************************
   // access and device widths
   // ****************************************************************
   // width of the connected device
   typedef enum logic [1:0] {EBLA_DEV8, EBLA_DEV16, EBLA_DEV32} ebla_width_type;
   // size of the internal access
   typedef enum logic [1:0] {EBLA_BYTE, EBLA_WORD, EBLA_LONG} ebla_size_type;

   // ****************************************************************
   // bus geometry and reset values
   // ****************************************************************
   localparam int EBLA_LANES = 4;                    // byte lanes of the external bus
   localparam int EBLA_DATA_W = 32;                  // external data bus width
   localparam logic [3:0] EBLA_NO_LANES = 4'h0;      // all strobes negated
   localparam logic [3:0] EBLA_ALL_LANES = 4'hF;     // all four lanes in use
   localparam logic [31:0] EBLA_DATA_RST = 32'h0000_0000; // data bus after reset
   localparam logic [1:0] EBLA_OFF_RST = 2'h0;       // offset after reset
endpackage

// ### design/ebla_map_if.sv
// carrier between the sequencer and the lane map
`timescale 1ns/1ps
interface ebla_map_if;
   import ebla_pkg::*;
   logic little_endian;            // endian mode in force
   ebla_width_type width;          // connected device width
   ebla_size_type size;            // access size
   logic [1:0] base;               // byte offset of the access
   logic [1:0] cyc;                // index of the split cycle
   logic [3:0] lane_en;            // lanes that carry data this cycle
   logic [1:0] lane_sel [4];       // access byte carried by each lane
   logic [1:0] cyc_off;            // byte offset put out with this cycle
   logic last;                     // this cycle finishes the access
   modport seq (output little_endian, width, size, base, cyc,
                input lane_en, lane_sel, cyc_off, last);
   modport map (input little_endian, width, size, base, cyc,
                output lane_en, lane_sel, cyc_off, last);
endinterface

// ### design/ebla_lane_map.sv
// lane map: which access byte sits on which lane in each split cycle
`timescale 1ns/1ps
module ebla_lane_map (
   ebla_map_if.map m
);
   import ebla_pkg::*;

   // ****************************************************************
   // chunk geometry
   // ****************************************************************
   logic [2:0] nbytes;    // bytes in the access
   logic [2:0] wbytes;    // bytes per device cycle
   logic [2:0] chunk;     // bytes moved per cycle
   logic [2:0] abase;     // access offset aligned to its size
   logic [2:0] cbase;     // first offset of this cycle
   logic [2:0] grp;       // device word that holds this cycle

   // sizes in bytes and start of the current cycle
   always_comb begin
      case (m.size)
         EBLA_BYTE: nbytes = 3'd1;
         EBLA_WORD: nbytes = 3'd2;
         default: nbytes = 3'd4;
      endcase
      case (m.width)
         EBLA_DEV8: wbytes = 3'd1;
         EBLA_DEV16: wbytes = 3'd2;
         default: wbytes = 3'd4;
      endcase
      chunk = (nbytes < wbytes) ? nbytes : wbytes;
      abase = {1'b0, m.base} & ~(nbytes - 3'd1);
      cbase = abase + ((chunk == 3'd4) ? 3'd0 : (chunk == 3'd2) ? {1'b0, m.cyc[0], 1'b0} :
                       {1'b0, m.cyc});
      grp = cbase & ~(wbytes - 3'd1);
   end

   // ascending cycles; the last one reaches the end of the access
   assign m.cyc_off = cbase[1:0];
   assign m.last = ((cbase + chunk) >= (abase + nbytes));

   // ****************************************************************
   // per lane steering
   // ****************************************************************
   for (genvar k = 0; k < EBLA_LANES; k++) begin : g_lane
      logic [2:0] pos;    // byte position inside the device word
      logic [2:0] addr;   // byte address served by this lane
      logic [2:0] rel;    // address relative to the access start
      // little endian: lowest address on lowest lane; big endian reversed
      assign pos = m.little_endian ? 3'(k) : (wbytes - 3'd1 - 3'(k));
      assign addr = grp | pos;
      assign rel = addr - abase;
      // lane used only inside the device width and inside this chunk
      assign m.lane_en[k] = (3'(k) < wbytes) && (addr >= cbase) && (addr < cbase + chunk);
      // big endian: lowest address holds the most significant byte
      assign m.lane_sel[k] = m.little_endian ? rel[1:0] : 2'(nbytes - 3'd1 - rel);
   end
endmodule

// ### dv/ebla_ext_model.sv
// behavioural model of the external memory on the far side of the lane bus
`timescale 1ns/1ps
module ebla_ext_model (
   input wire logic clk,
   input wire logic ext_valid,
   input wire logic [1:0] ext_offset,
   output logic [31:0] ext_rdata
);
   // ****************************************************************
   // read data
   // ****************************************************************
   logic [31:0] last_q = 32'h5A5A_5A5A; // value last driven while selected

   // selected: a pattern unique to each offset; released: inverse of last value
   always_comb begin
      if (ext_valid) begin
         ext_rdata = 32'hC6A5_7E31 ^ {4{6'h00, ext_offset}};
      end else begin
         ext_rdata = ~last_q;
      end
   end

   // remember the value of each device cycle
   always @(posedge clk) begin
      if (ext_valid) begin
         last_q <= ext_rdata;
      end
   end
endmodule

// ### dv/ebla_tb.sv
// self-checking bench for lane steering and access splitting
`timescale 1ns/1ps
module ebla_tb;
   import ebla_pkg::*;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic clk, rst_b, endian_select_pin, req_valid, req_write, le_q;
   ebla_width_type dev_width; // device width under test
   ebla_size_type req_size; // access size under test
   logic [1:0] req_offset, ext_offset;
   logic [31:0] req_wdata, rsp_rdata, ext_wdata, ext_rdata;
   logic req_ready, rsp_done, ext_valid, ext_write, ext_last;
   logic [3:0] strobe, mask; // lane write strobes and byte masks
   int failures = 0, samples_checked = 0, cycles = 0;

   ebla_top i_ebla_top (.clk(clk), .rst_b(rst_b), .endian_select_pin(endian_select_pin),
      .dev_width(dev_width), .req_valid(req_valid), .req_write(req_write),
      .req_size(req_size), .req_offset(req_offset), .req_wdata(req_wdata),
      .req_ready(req_ready), .rsp_done(rsp_done), .rsp_rdata(rsp_rdata),
      .ext_valid(ext_valid), .ext_write(ext_write), .ext_last(ext_last),
      .ext_offset(ext_offset), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
      .lane0_write_strobe(strobe[0]), .lane1_write_strobe(strobe[1]),
      .lane2_write_strobe(strobe[2]), .lane3_write_strobe(strobe[3]),
      .lane0_byte_mask(mask[0]), .lane1_byte_mask(mask[1]),
      .lane2_byte_mask(mask[2]), .lane3_byte_mask(mask[3]));

   ebla_ext_model i_ebla_ext_model (.clk(clk), .ext_valid(ext_valid),
      .ext_offset(ext_offset), .ext_rdata(ext_rdata));

   // ****************************************************************
   // helpers
   // ****************************************************************
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         failures++;
         finish_test();
      end
   end

   // same pattern the external model returns
   function automatic logic [31:0] rd_pattern(logic [1:0] off);
      return 32'hC6A5_7E31 ^ {4{6'h00, off}};
   endfunction

   // lane that carries byte address a
   function automatic int lane_of(ebla_width_type w, logic le, int a);
      if (w == EBLA_DEV32) return le ? a % 4 : 3 - a % 4;
      if (w == EBLA_DEV16) return le ? a % 2 : 1 - a % 2;
      return 0;
   endfunction

   task automatic check(logic [63:0] got, logic [63:0] exp, string msg);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   // reset with a strap value, then flip the strap to show it is held
   task automatic do_reset(logic le);
      @(negedge clk);
      rst_b = 1'b0;
      endian_select_pin = le;
      le_q = le;
      repeat (12) @(negedge clk);
      check({req_ready, rsp_done, ext_valid, mask, strobe}, 64'h0, "outputs in reset");
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      endian_select_pin = ~le;
   endtask

   // one access, every split cycle and the completion judged
   task automatic access(ebla_width_type w, ebla_size_type sz, int off, logic wr);
      int nb, cb, base, n, a, idx, ln, k, i;
      logic [31:0] val, expw, exprd, pat;
      logic [3:0] expm;
      logic [1:0] eo;
      nb = 1 << int'(sz);
      cb = (w == EBLA_DEV8) ? 1 : (w == EBLA_DEV16) ? 2 : 4;
      if (cb > nb) cb = nb;
      base = off - off % nb;
      n = nb / cb;
      val = 32'h8B4D_E217;
      if (nb < 4) val = val & ~(32'hFFFF_FFFF << (8 * nb));
      exprd = 32'h0000_0000;
      @(negedge clk);
      dev_width = w;
      req_size = sz;
      req_offset = 2'(off);
      req_write = wr;
      req_wdata = val;
      req_valid = 1'b1;
      k = 0;
      while (req_ready !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      @(negedge clk);
      req_valid = 1'b0;
      for (k = 0; k < n; k++) begin
         @(negedge clk);
         expw = 32'h0000_0000;
         expm = 4'h0;
         eo = 2'(base + k * cb);
         pat = rd_pattern(eo);
         for (i = 0; i < cb; i++) begin
            a = base + k * cb + i;
            idx = le_q ? a - base : nb - 1 - (a - base);
            ln = lane_of(w, le_q, a);
            expm[ln] = 1'b1;
            expw[8 * ln +: 8] = val[8 * idx +: 8];
            exprd[8 * idx +: 8] = pat[8 * ln +: 8];
         end
         check({ext_valid, ext_write, ext_last, ext_offset, mask, strobe,
                wr ? ext_wdata : expw},
               {1'b1, wr, k == n - 1, eo, expm, wr ? expm : 4'h0, expw},
               "lane cycle");
      end
      @(negedge clk);
      check({ext_valid, mask, strobe}, 64'h0, "idle lanes");
      k = 0;
      while (rsp_done !== 1'b1 && k < 3) begin
         @(negedge clk);
         k++;
      end
      check({rsp_done, wr ? 32'h0000_0000 : rsp_rdata}, {1'b1, wr ? 32'h0000_0000 : exprd},
            "completion");
   endtask

   // bytes at every offset, words at 0 and 2, a longword; writes then reads
   task automatic sweep(ebla_width_type w);
      for (int t = 0; t < 2; t++) begin
         for (int o = 0; o < 4; o++) access(w, EBLA_BYTE, o, t == 0);
         access(w, EBLA_WORD, 0, t == 0);
         access(w, EBLA_WORD, 2, t == 0);
         access(w, EBLA_LONG, 0, t == 0);
      end
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic test_big_narrow;
      do_reset(1'b0);
      sweep(EBLA_DEV8);
      sweep(EBLA_DEV16);
   endtask

   task automatic test_little_wide;
      do_reset(1'b1);
      sweep(EBLA_DEV32);
   endtask

   task automatic test_little_narrow;
      sweep(EBLA_DEV16);
      sweep(EBLA_DEV8);
      access(EBLA_DEV8, EBLA_WORD, 3, 1'b1);
   endtask

   task automatic test_big_wide;
      do_reset(1'b0);
      sweep(EBLA_DEV32);
   endtask

   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      rst_b = 1'b0;
      endian_select_pin = 1'b0;
      le_q = 1'b0;
      dev_width = EBLA_DEV32;
      req_size = EBLA_BYTE;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_offset = 2'h0;
      req_wdata = 32'h0000_0000;
      test_big_narrow();
      test_little_wide();
      test_little_narrow();
      test_big_wide();
      finish_test();
   end
endmodule
